// file: core/reset_mode_strap.sv
// Notes on behaviour
// RULE_01: straps sampled from pins during cold reset
// RULE_02: latched at cold reset release, then frozen
// RULE_03: three-bit field picks clock multiplier 2/3/4
// RULE_04: mode bit 3 low little, high big
// RULE_05: mode bit 6 low routes timer irq
// RULE_06: board straps bits 4,5 zero, bit 7 one
// RULE_07: width strap 00/01/10 gives 8/16/32 bits
// RULE_08: non-boot mode moves register base upward
// RULE_09: source 11 floats buses during cold reset
// RULE_10: pci boot accepts cold or pci reset
// RULE_11: pci boot needs satellite; source 10 illegal
// RULE_12: source 00 boots from local memory
// RULE_13: address line 20 high satellite, low host
// RULE_14: host software programs all pci config registers
// RULE_15: satellite pci boot loads config from eeprom
// RULE_16: source pin high for cpu, low dma
// RULE_17: ack pin low on any data acknowledge
// RULE_18: strobe low at start, block address out
// RULE_19: i/d pin low data, high instruction
`timescale 1ns/1ns
`default_nettype none
module reset_mode_strap
  import strap_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cold_reset_n_i,
  input wire logic pci_reset_n_i,
  input wire logic [2:0] pcst_strap_i,
  input wire logic dbg_i_d_n_i,
  input wire logic dbg_ack_n_i,
  input wire logic dbg_ads_n_i,
  input wire logic dbg_dma_n_i,
  input wire logic [22:17] mem_addr_i,
  output logic dbg_i_d_n_o,
  output logic dbg_i_d_n_oe_o,
  output logic dbg_ack_n_o,
  output logic dbg_ack_n_oe_o,
  output logic dbg_ads_n_o,
  output logic dbg_ads_n_oe_o,
  output logic dbg_dma_n_o,
  output logic dbg_dma_n_oe_o,
  output logic [31:4] mem_data_o,
  output logic mem_data_oe_o,
  input wire logic txn_ads_i,
  input wire logic txn_ack_i,
  input wire logic txn_cpu_i,
  input wire logic txn_instr_i,
  input wire logic [27:0] txn_blk_addr_i,
  output logic [2:0] core_pipeline_clock_mult_o,
  output logic byte_order_select_o,
  output logic timer_irq_route_en_o,
  output logic [1:0] boot_width_o,
  output logic [31:0] reg_base_o,
  output logic [1:0] boot_src_o,
  output logic pci_satellite_o,
  output logic eeprom_cfg_load_o,
  output logic bus_float_o,
  output logic core_reset_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o
);
  typedef struct packed {
    logic cold_rel;
    logic [MODE_W-1:0] sh_mode;
    logic [1:0] sh_src;
    logic sh_sat;
    logic [MODE_W-1:0] mode;
    logic [1:0] src;
    logic sat;
    logic float_bus;
    logic core_rst;
    logic load;
    logic trace_en;
    logic ack;
    logic err;
    logic [31:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [MODE_W-1:0] pin_mode;
  logic release_edge;
  logic req;
  logic [31:0] stat;
  logic [2:0] mult_sel;
  logic [1:0] width_sel;

  trace_if tr ();

  // base depends only on the frozen source field
  function automatic logic [31:0] reg_base(input logic [1:0] src);
    reg_base = (src == BOOT_FLOAT) ? REG_BASE_ALT : REG_BASE_BOOT; // RULE_08
  endfunction : reg_base

  // RULE_01
  assign pin_mode = {mem_addr_i[19:18], mem_addr_i[17], dbg_dma_n_i,
                     dbg_ads_n_i, dbg_ack_n_i, dbg_i_d_n_i, pcst_strap_i};
  assign release_edge = cold_reset_n_i & ~s_q.cold_rel;
  assign req = wb_cyc_i & wb_stb_i;
  assign mult_sel = s_q.mode[MB_MULT_LSB +: MB_MULT_W];
  assign width_sel = s_q.mode[MB_WIDTH_LSB +: 2];

  always_comb begin
    stat = '0;
    stat[ST_COLD] = ~s_q.cold_rel;
    stat[ST_MULT_RSV] = mult_sel > MULT_X4;
    stat[ST_WIDTH_RSV] = width_sel == WIDTH_RSV;
    // far-side strap mistakes are reported, not corrected
    stat[ST_SRC_RSV] = s_q.src == BOOT_RSV; // RULE_11
    stat[ST_PCI_HOST] = (s_q.src == BOOT_PCI) & ~s_q.sat; // RULE_11
    stat[ST_RSV45] = s_q.mode[MB_RSV4] | s_q.mode[MB_RSV5]; // RULE_06
    stat[ST_RSV7] = ~s_q.mode[MB_RSV7]; // RULE_06
  end

  always_comb begin
    s_d = s_q;
    s_d.cold_rel = cold_reset_n_i;
    s_d.load = 1'b0;
    if (!cold_reset_n_i) begin
      s_d.sh_mode = pin_mode; // RULE_01
      s_d.sh_src = mem_addr_i[22:21];
      s_d.sh_sat = mem_addr_i[20]; // RULE_13
    end
    if (release_edge) begin
      // only this edge writes the live settings
      s_d.mode = s_q.sh_mode; // RULE_02
      s_d.src = s_q.sh_src; // RULE_02
      s_d.sat = s_q.sh_sat; // RULE_02
      // host role leaves config to software, so no load then
      s_d.load = (s_q.sh_src == BOOT_PCI) & s_q.sh_sat; // RULE_15 RULE_14
    end
    s_d.float_bus = ~cold_reset_n_i & (mem_addr_i[22:21] == BOOT_FLOAT); // RULE_09
    s_d.core_rst = ~cold_reset_n_i |
                   ((s_q.src == BOOT_PCI) & ~pci_reset_n_i); // RULE_10
    s_d.ack = 1'b0;
    s_d.err = 1'b0;
    if (req && !s_q.ack && !s_q.err) begin
      s_d.rdata = '0;
      unique case (wb_adr_i)
        ADR_MODE: begin
          s_d.ack = 1'b1;
          s_d.rdata[MODE_W-1:0] = s_q.mode;
          s_d.rdata[MODE_SRC_LSB +: 2] = s_q.src;
          s_d.rdata[MODE_SAT] = s_q.sat;
        end
        ADR_CTRL: begin
          s_d.ack = 1'b1;
          s_d.rdata[CTRL_TRACE_EN] = s_q.trace_en;
          if (wb_we_i && wb_sel_i[0]) begin
            s_d.trace_en = wb_dat_i[CTRL_TRACE_EN];
          end
        end
        ADR_STAT: begin
          s_d.ack = 1'b1;
          s_d.rdata = stat;
        end
        ADR_BASE: begin
          s_d.ack = 1'b1;
          s_d.rdata = reg_base(s_q.src);
        end
        default: begin
          s_d.err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '{cold_rel: 1'b0, sh_mode: MODE_RST, sh_src: BOOT_STD,
               sh_sat: 1'b0, mode: MODE_RST, src: BOOT_STD, sat: 1'b0,
               float_bus: 1'b0, core_rst: 1'b1, load: 1'b0,
               trace_en: CTRL_TRACE_EN_RST, ack: 1'b0, err: 1'b0,
               rdata: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // RULE_03
  always_comb begin
    unique case (mult_sel)
      MULT_X3: core_pipeline_clock_mult_o = FACTOR_3;
      MULT_X4: core_pipeline_clock_mult_o = FACTOR_4;
      // reserved codes fall back to the slowest core clock
      default: core_pipeline_clock_mult_o = FACTOR_2;
    endcase
  end

  assign byte_order_select_o = s_q.mode[MB_ENDIAN]; // RULE_04
  assign timer_irq_route_en_o = ~s_q.mode[MB_TMR]; // RULE_05
  assign boot_width_o = width_sel; // RULE_07
  assign reg_base_o = reg_base(s_q.src); // RULE_08
  assign boot_src_o = s_q.src; // RULE_12
  assign pci_satellite_o = s_q.sat; // RULE_13
  assign eeprom_cfg_load_o = s_q.load;
  assign bus_float_o = s_q.float_bus;
  assign core_reset_o = s_q.core_rst;
  assign wb_dat_o = s_q.rdata;
  assign wb_ack_o = s_q.ack;
  assign wb_err_o = s_q.err;

  // pins stay released while straps are being read
  assign tr.en = s_q.cold_rel & cold_reset_n_i & s_q.trace_en;
  assign tr.ads = txn_ads_i;
  assign tr.ack = txn_ack_i;
  assign tr.cpu = txn_cpu_i;
  assign tr.instr = txn_instr_i;
  assign tr.addr = txn_blk_addr_i;

  logic pin_oe;

  trace_drive u_drive (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .t(tr.drv),
    .dma_n_o(dbg_dma_n_o),
    .ack_n_o(dbg_ack_n_o),
    .ads_n_o(dbg_ads_n_o),
    .i_d_n_o(dbg_i_d_n_o),
    .pin_oe_o(pin_oe),
    .data_o(mem_data_o),
    .data_oe_o(mem_data_oe_o)
  );

  assign dbg_i_d_n_oe_o = pin_oe;
  assign dbg_ack_n_oe_o = pin_oe;
  assign dbg_ads_n_oe_o = pin_oe;
  assign dbg_dma_n_oe_o = pin_oe;
endmodule : reset_mode_strap
`default_nettype wire

// file: core/strap_pkg.sv
package strap_pkg;
  // mode word layout
  localparam int MODE_W = 10;
  localparam int MB_MULT_LSB = 0;
  localparam int MB_MULT_W = 3;
  localparam int MB_ENDIAN = 3;
  localparam int MB_RSV4 = 4;
  localparam int MB_RSV5 = 5;
  localparam int MB_TMR = 6;
  localparam int MB_RSV7 = 7;
  localparam int MB_WIDTH_LSB = 8;
  localparam logic [MODE_W-1:0] MODE_RST = 10'h080;
  // multiplier selects and resulting factors
  localparam logic [2:0] MULT_X2 = 3'h0;
  localparam logic [2:0] MULT_X3 = 3'h1;
  localparam logic [2:0] MULT_X4 = 3'h2;
  localparam logic [2:0] FACTOR_2 = 3'h2;
  localparam logic [2:0] FACTOR_3 = 3'h3;
  localparam logic [2:0] FACTOR_4 = 3'h4;
  // boot memory width codes
  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;
  localparam logic [1:0] WIDTH_RSV = 2'h3;
  typedef enum logic [1:0] {
    BOOT_STD = 2'h0,
    BOOT_PCI = 2'h1,
    BOOT_RSV = 2'h2,
    BOOT_FLOAT = 2'h3
  } boot_src_t;
  localparam logic [31:0] REG_BASE_BOOT = 32'h1800_0000;
  localparam logic [31:0] REG_BASE_ALT = 32'h1900_0000;
  // register map
  localparam logic [7:0] ADR_MODE = 8'h00;
  localparam logic [7:0] ADR_CTRL = 8'h04;
  localparam logic [7:0] ADR_STAT = 8'h08;
  localparam logic [7:0] ADR_BASE = 8'h0c;
  localparam int MODE_SRC_LSB = 10;
  localparam int MODE_SAT = 12;
  localparam int CTRL_TRACE_EN = 0;
  localparam logic CTRL_TRACE_EN_RST = 1'b1;
  localparam int ST_COLD = 0;
  localparam int ST_MULT_RSV = 1;
  localparam int ST_WIDTH_RSV = 2;
  localparam int ST_SRC_RSV = 3;
  localparam int ST_PCI_HOST = 4;
  localparam int ST_RSV45 = 5;
  localparam int ST_RSV7 = 6;
endpackage : strap_pkg

// file: core/trace_drive.sv
`timescale 1ns/1ns
`default_nettype none
module trace_drive
  import strap_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  trace_if.drv t,
  output logic dma_n_o,
  output logic ack_n_o,
  output logic ads_n_o,
  output logic i_d_n_o,
  output logic pin_oe_o,
  output logic [31:4] data_o,
  output logic data_oe_o
);
  typedef struct packed {
    logic dma_n;
    logic ack_n;
    logic ads_n;
    logic i_d_n;
    logic oe;
    logic [27:0] data;
    logic data_oe;
  } drv_t;
  drv_t s_q;
  drv_t s_d;
  logic live;

  always_comb begin
    s_d = s_q;
    live = t.ads | t.ack;
    s_d.oe = t.en;
    s_d.ads_n = ~(t.en & t.ads); // RULE_18
    s_d.ack_n = ~(t.en & t.ack); // RULE_17
    // idle level high keeps a probe from seeing a phantom dma cycle
    s_d.dma_n = live ? t.cpu : 1'b1; // RULE_16
    s_d.i_d_n = live ? t.instr : 1'b1; // RULE_19
    s_d.data_oe = t.en & t.ads; // RULE_18
    if (t.ads) begin
      s_d.data = t.addr; // RULE_18
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '{dma_n: 1'b1, ack_n: 1'b1, ads_n: 1'b1, i_d_n: 1'b1,
               oe: 1'b0, data: '0, data_oe: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign dma_n_o = s_q.dma_n;
  assign ack_n_o = s_q.ack_n;
  assign ads_n_o = s_q.ads_n;
  assign i_d_n_o = s_q.i_d_n;
  assign pin_oe_o = s_q.oe;
  assign data_o = s_q.data;
  assign data_oe_o = s_q.data_oe;
endmodule : trace_drive
`default_nettype wire

// file: core/trace_if.sv
`timescale 1ns/1ns
`default_nettype none
interface trace_if;
  logic en;
  logic ads;
  logic ack;
  logic cpu;
  logic instr;
  logic [27:0] addr;
  modport src (output en, ads, ack, cpu, instr, addr);
  modport drv (input en, ads, ack, cpu, instr, addr);
endinterface : trace_if
`default_nettype wire

// file: sim/reset_mode_strap_and_bus_trace_tb.sv
`timescale 1ns/1ns
`default_nettype none
module reset_mode_strap_and_bus_trace_tb;
  import strap_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cold_reset_n_i = 1'b0, pci_reset_n_i = 1'b1;
  logic txn_ads_i = 1'b0, txn_ack_i = 1'b0, txn_cpu_i = 1'b0;
  logic txn_instr_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [27:0] txn_blk_addr_i = 28'h0;
  logic [7:0] wb_adr_i = 8'h0;
  logic [3:0] wb_sel_i = 4'hf, pn;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, reg_base_o, rd;
  logic [2:0] pcst_strap_i, core_pipeline_clock_mult_o;
  logic [22:17] mem_addr_i;
  logic [31:4] mem_data_o;
  logic [9:0] cfg = 10'h0;
  logic [1:0] boot_width_o, boot_src_o;
  logic dbg_i_d_n_o, dbg_i_d_n_oe_o, dbg_ack_n_o, dbg_ack_n_oe_o, er;
  logic dbg_ads_n_o, dbg_ads_n_oe_o, dbg_dma_n_o, dbg_dma_n_oe_o, mem_data_oe_o;
  logic byte_order_select_o, timer_irq_route_en_o, pci_satellite_o, core_reset_o;
  logic eeprom_cfg_load_o, bus_float_o, wb_ack_o, wb_err_o;
  int fail_count = 0, samples_checked = 0, ticks = 0;
  // shared pins: design wins while enabled, else the board
  wire dbg_i_d_n_i = dbg_i_d_n_oe_o ? dbg_i_d_n_o : pn[0];
  wire dbg_ack_n_i = dbg_ack_n_oe_o ? dbg_ack_n_o : pn[1];
  wire dbg_ads_n_i = dbg_ads_n_oe_o ? dbg_ads_n_o : pn[2];
  wire dbg_dma_n_i = dbg_dma_n_oe_o ? dbg_dma_n_o : pn[3];
  reset_mode_strap u_dut (.*);
  strap_board u_board (.clk_i(clk_i), .cold_reset_n_i(cold_reset_n_i),
    .cfg_i(cfg), .pin_n_o(pn), .pcst_o(pcst_strap_i), .addr_o(mem_addr_i));
  task automatic end_of_test();
    $display("fail_count=%0d samples_checked=%0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    rd = wb_dat_o;
    er = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic boot(input logic [9:0] c);
    logic s;
    int e;
    s = c[7] | (c[9:8] == 2'h1);
    e = 0;
    @(posedge clk_i);
    cold_reset_n_i <= 1'b0;
    cfg <= c;
    repeat (3) @(posedge clk_i);
    chk(bus_float_o, &c[9:8]);
    cold_reset_n_i <= 1'b1;
    repeat (6) begin
      @(posedge clk_i);
      e += eeprom_cfg_load_o;
    end
    wb(1'b0, ADR_MODE, 32'h0);
    chk(rd, {19'h0, s, c[9:8], c[6:5], 1'b1, c[4], 2'h0, c[3:0]});
    wb(1'b0, ADR_STAT, 32'h0);
    chk(rd, {29'h0, c[6:5] == WIDTH_RSV,
      c[2:0] > MULT_X4, 1'b0});
    chk(core_pipeline_clock_mult_o, c[2:0] == MULT_X3 ? FACTOR_3 :
      c[2:0] == MULT_X4 ? FACTOR_4 : FACTOR_2);
    chk(byte_order_select_o, c[3]);
    chk(timer_irq_route_en_o, !c[4]);
    chk(boot_width_o, c[6:5]);
    chk({boot_src_o, pci_satellite_o}, {c[9:8], s});
    chk(reg_base_o, &c[9:8] ? REG_BASE_ALT : REG_BASE_BOOT);
    chk(e, c[9:8] == 2'h1);
    pci_reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(core_reset_o, c[9:8] == 2'h1);
    pci_reset_n_i <= 1'b1;
  endtask : boot
  task automatic txn(input logic [3:0] v, input logic on);
    logic [27:0] b;
    logic [3:0] p;
    b = {24'ha5c3e1, v};
    @(posedge clk_i);
    {txn_ads_i, txn_ack_i, txn_cpu_i, txn_instr_i} <= v;
    txn_blk_addr_i <= b;
    @(posedge clk_i);
    {txn_ads_i, txn_ack_i} <= 2'h0;
    @(posedge clk_i);
    p = {dbg_ads_n_o, dbg_ack_n_o, dbg_dma_n_o, dbg_i_d_n_o};
    chk(p, {on ? ~v[3:2] : 2'h3, v[1:0]});
    chk({dbg_ads_n_oe_o, dbg_ack_n_oe_o, dbg_dma_n_oe_o,
      dbg_i_d_n_oe_o, mem_data_oe_o}, on ? {4'hf, v[3]} : 5'h0);
    if (on && v[3]) chk(mem_data_o, b);
  endtask : txn
  initial forever #4 clk_i = ~clk_i;
  always @(posedge clk_i) if (++ticks == 3000) begin
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    boot(10'h000);
    boot(10'h1b9);
    boot(10'h352);
    boot(10'h0ed);
    for (int i = 0; i < 4; i++) txn({i[1], !i[1], i[0], i[1] ^ i[0]}, 1'b1);
    wb(1'b1, ADR_CTRL, 32'h0);
    wb(1'b0, ADR_CTRL, 32'h0);
    chk(rd, 32'h0);
    txn(4'ha, 1'b0);
    wb(1'b1, ADR_BASE, 32'h0);
    wb(1'b0, ADR_BASE, 32'h0);
    chk(rd, REG_BASE_BOOT);
    wb(1'b0, 8'h10, 32'h0);
    chk(er, 1'b1);
    end_of_test();
  end
endmodule : reset_mode_strap_and_bus_trace_tb
`default_nettype wire

// file: sim/rms_checker.sv
`timescale 1ns/1ns
`default_nettype none
module rms_checker
  import strap_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cold_reset_n_i,
  input wire logic pci_reset_n_i,
  input wire logic [2:0] pcst_strap_i,
  input wire logic dbg_i_d_n_i,
  input wire logic dbg_ack_n_i,
  input wire logic dbg_ads_n_i,
  input wire logic dbg_dma_n_i,
  input wire logic [22:17] mem_addr_i,
  input wire logic dbg_i_d_n_o,
  input wire logic dbg_ack_n_o,
  input wire logic dbg_ads_n_o,
  input wire logic dbg_ads_n_oe_o,
  input wire logic dbg_dma_n_o,
  input wire logic txn_ads_i,
  input wire logic txn_ack_i,
  input wire logic txn_cpu_i,
  input wire logic txn_instr_i,
  input wire logic [2:0] core_pipeline_clock_mult_o,
  input wire logic byte_order_select_o,
  input wire logic timer_irq_route_en_o,
  input wire logic [1:0] boot_width_o,
  input wire logic [31:0] reg_base_o,
  input wire logic [1:0] boot_src_o,
  input wire logic pci_satellite_o,
  input wire logic bus_float_o,
  input wire logic core_reset_o
);
  logic [12:0] s_q;
  logic [2:0] n_q;
  wire lk = n_q == 3'h4;
  // lock only after a real strap phase; skips the one-edge output lag
  always_ff @(posedge clk_i) begin
    if (!cold_reset_n_i) s_q <= {mem_addr_i, dbg_dma_n_i, dbg_ads_n_i,
      dbg_ack_n_i, dbg_i_d_n_i, pcst_strap_i};
    if (rst_i) n_q <= 3'h0;
    else if (!cold_reset_n_i) n_q <= 3'h1;
    else if (n_q != 3'h0 && !lk) n_q <= n_q + 3'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_HOLD: assert property (lk |-> $stable({boot_src_o, boot_width_o}))
    else $error("config moved");
  AST_MULT: assert property (lk |-> core_pipeline_clock_mult_o ==
    (s_q[2:0] == MULT_X3 ? FACTOR_3 : s_q[2:0] == MULT_X4 ? FACTOR_4 : FACTOR_2))
    else $error("multiplier wrong");
  AST_FIELD: assert property (lk |-> {byte_order_select_o,
    timer_irq_route_en_o, boot_width_o} == {s_q[3], !s_q[6], s_q[9:8]})
    else $error("mode field wrong");
  AST_BASE: assert property (lk |-> reg_base_o == (&s_q[12:11] ?
    REG_BASE_ALT : REG_BASE_BOOT)) else $error("base wrong");
  AST_ROLE: assert property (lk |-> {boot_src_o, pci_satellite_o} == s_q[12:10])
    else $error("role wrong");
  AST_FLOAT: assert property (!$past(cold_reset_n_i) && !$past(rst_i) &&
    &$past(mem_addr_i[22:21]) |-> bus_float_o) else $error("bus not floated");
  AST_PCIRST: assert property (lk |-> core_reset_o ==
    (boot_src_o == BOOT_PCI && !$past(pci_reset_n_i))) else $error("core reset");
  AST_QUIET: assert property (!$past(cold_reset_n_i) |-> !dbg_ads_n_oe_o)
    else $error("trace driven in reset");
  AST_STROBE: assert property (dbg_ads_n_oe_o |-> {dbg_ads_n_o,
    dbg_ack_n_o} == ~{$past(txn_ads_i), $past(txn_ack_i)}) else $error("strobe");
  AST_KIND: assert property (dbg_ads_n_oe_o && $past(txn_ads_i) |->
    {dbg_dma_n_o, dbg_i_d_n_o} == {$past(txn_cpu_i), $past(txn_instr_i)})
    else $error("kind wrong");
endmodule : rms_checker
bind reset_mode_strap rms_checker u_chk (.*);
`default_nettype wire

// file: sim/strap_board.sv
`timescale 1ns/1ns
`default_nettype none
module strap_board (
  input wire logic clk_i,
  input wire logic cold_reset_n_i,
  input wire logic [9:0] cfg_i,
  output logic [3:0] pin_n_o,
  output logic [2:0] pcst_o,
  output logic [22:17] addr_o
);
  logic [12:0] junk_q = 13'h0;
  logic sat;
  // released straps toggle so a stale capture cannot pass
  always_ff @(posedge clk_i) junk_q <= ~junk_q;
  always_comb begin
    sat = cfg_i[7] | (cfg_i[9:8] == 2'h1);
    if (!cold_reset_n_i) begin
      {addr_o, pin_n_o, pcst_o} = {cfg_i[9:8], sat, cfg_i[6:5], 1'b1,
        cfg_i[4], 2'h0, cfg_i[3:0]};
    end else begin
      {addr_o, pin_n_o, pcst_o} = junk_q;
    end
  end
endmodule : strap_board
`default_nettype wire
